// ### hdl/fic_pkg.sv
// constants, tables and carrier types for the four level interrupt controller
// assumes one clock domain; offsets are word indices on an 8-bit register port
package fic_pkg;

  // ************************************************************
  // register port geometry and map
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_ENABLE_A = 4'h0;
  localparam logic [3:0] OFS_ENABLE_B = 4'h1;
  localparam logic [3:0] OFS_PRIO_LOW_A = 4'h2;
  localparam logic [3:0] OFS_PRIO_HIGH_A = 4'h3;
  localparam logic [3:0] OFS_PRIO_LOW_B = 4'h4;
  localparam logic [3:0] OFS_PRIO_HIGH_B = 4'h5;
  localparam logic [3:0] OFS_SERIAL_STATUS = 4'h6;
  localparam logic [3:0] OFS_EVT_STATUS = 4'h7;
  localparam logic [3:0] OFS_EVT_CLEAR = 4'h8;
  localparam logic [3:0] OFS_EVT_ENABLE = 4'h9;
  localparam logic [3:0] OFS_SERVICE = 4'ha;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_SPLIT = 5;
  localparam int BIT_EXTRA = 0;
  localparam logic [7:0] SERIAL_CFG_MASK = 8'h21;

  // ************************************************************
  // sources: index order, enable/priority bit, bank, rank, vector
  // ************************************************************
  localparam int NSRC = 8;
  localparam logic [2:0] SRC_T0 = 3'h0;
  localparam logic [2:0] SRC_T1 = 3'h1;
  localparam logic [2:0] SRC_SER = 3'h2;
  localparam logic [2:0] SRC_BO = 3'h3;
  localparam logic [2:0] SRC_WD = 3'h4;
  localparam logic [2:0] SRC_KB = 3'h5;
  localparam logic [2:0] SRC_CM = 3'h6;
  localparam logic [2:0] SRC_STX = 3'h7;
  localparam logic [2:0] SRC_BIT [0:7] = '{3'h1, 3'h3, 3'h4, 3'h5,
                                          3'h6, 3'h1, 3'h2, 3'h6};
  localparam logic [7:0] SRC_IN_B = 8'he0;
  localparam logic [3:0] SRC_RANK [0:7] = '{4'h3, 4'h5, 4'h8, 4'h1,
                                           4'h2, 4'h4, 4'h6, 4'h7};
  localparam logic [15:0] SRC_VEC [0:7] = '{16'h000b, 16'h001b, 16'h0023,
                                           16'h002b, 16'h0053, 16'h003b,
                                           16'h0043, 16'h006b};
  localparam logic [7:0] WAKE_MASK = 8'h78;

  // ************************************************************
  // events of the controller itself
  // ************************************************************
  localparam int EV_ENTRY = 0;
  localparam int EV_NEST = 1;
  localparam int EV_RETURN = 2;
  localparam int EV_STRAY = 3;

  typedef struct packed {
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] pl_a;
    logic [7:0] ph_a;
    logic [7:0] pl_b;
    logic [7:0] ph_b;
    logic [7:0] ser_cfg;
    logic [3:0] st;
    logic [3:0] ie;
    logic [3:0] in_svc;
    logic req;
    logic [1:0] lvl;
    logic [2:0] src;
    logic [15:0] vec;
    logic [7:0] rdata;
    logic wake;
  } fic_state_type;

  typedef struct packed {
    logic timer_zero_flag;
    logic timer_one_flag;
    logic brownout_flag;
    logic watchdog_overflow_flag;
    logic clock_alarm_flag;
    logic keypad_flag;
    logic comparator_flag;
    logic serial_tx_flag;
    logic serial_rx_flag;
    logic framing_error_flag;
    logic break_flag;
    logic overrun_flag;
  } fic_flags_type;

endpackage

// ### hdl/fic_ctrl.sv
// four level prioritised interrupt controller with vector output
// assumes flags come from same-clock peripheral logic and a core that
// marks instruction boundaries, acknowledges vectors and reports returns
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module fic_ctrl
  import fic_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [DATA_W-1:0] RDATA_OUT,
  // interrupt sources
  input wire fic_flags_type FLAGS_IN,
  // core side
  input wire logic BOUNDARY_IN,
  input wire logic ACK_IN,
  input wire logic RETI_IN,
  output logic REQ_OUT,
  output logic [15:0] VECTOR_OUT,
  output logic [1:0] LEVEL_OUT,
  output logic WAKE_OUT,
  // controller event interrupt
  output logic IRQ_OUT
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic pick_bit(input logic [2:0] i,
                                    input logic [7:0] a,
                                    input logic [7:0] b);
    pick_bit = SRC_IN_B[i] ? b[SRC_BIT[i]] : a[SRC_BIT[i]];
  endfunction

  function automatic logic [1:0] src_level(input logic [2:0] i,
                                           input fic_state_type s);
    src_level = {pick_bit(i, s.ph_a, s.ph_b),
                 pick_bit(i, s.pl_a, s.pl_b)};
  endfunction

  fic_state_type q, d;
  logic [7:0] raw;
  logic [7:0] cand;
  logic found;
  logic [2:0] win_src;
  logic [1:0] win_lvl;
  logic [3:0] win_rank;
  logic svc_any;
  logic [1:0] svc_top;
  logic allowed;
  logic [3:0] ev;
  logic [7:0] rd_val;

  // ************************************************************
  // source requests
  // ************************************************************
  always_comb begin
    logic split;
    logic extra;
    split = q.ser_cfg[BIT_SPLIT];
    extra = q.ser_cfg[BIT_EXTRA];
    raw = '0;
    raw[SRC_T0] = FLAGS_IN.timer_zero_flag;
    raw[SRC_T1] = FLAGS_IN.timer_one_flag;
    raw[SRC_SER] = FLAGS_IN.serial_rx_flag
      | (FLAGS_IN.serial_tx_flag & ~split)
      | (extra & (FLAGS_IN.framing_error_flag | FLAGS_IN.break_flag
                  | FLAGS_IN.overrun_flag));
    raw[SRC_BO] = FLAGS_IN.brownout_flag;
    raw[SRC_WD] = FLAGS_IN.watchdog_overflow_flag
      | FLAGS_IN.clock_alarm_flag;
    raw[SRC_KB] = FLAGS_IN.keypad_flag;
    raw[SRC_CM] = FLAGS_IN.comparator_flag;
    raw[SRC_STX] = FLAGS_IN.serial_tx_flag & split;
    for (int i = 0; i < NSRC; i++) begin
      cand[i] = raw[i] & pick_bit(3'(i), q.en_a, q.en_b)
        & q.en_a[BIT_GLOBAL];
    end
  end

  // ************************************************************
  // arbitration
  // ************************************************************
  always_comb begin
    found = 1'b0;
    win_src = '0;
    win_lvl = '0;
    win_rank = '1;
    for (int i = 0; i < NSRC; i++) begin
      if (cand[i]) begin
        if (!found || src_level(3'(i), q) > win_lvl
            || (src_level(3'(i), q) == win_lvl
                && SRC_RANK[i] < win_rank)) begin
          found = 1'b1;
          win_src = 3'(i);
          win_lvl = src_level(3'(i), q);
          win_rank = SRC_RANK[i];
        end
      end
    end
    svc_any = |q.in_svc;
    svc_top = '0;
    for (int l = 0; l < 4; l++) begin
      if (q.in_svc[l]) begin
        svc_top = 2'(l);
      end
    end
    // level 3 in service can never be exceeded, so it is never preempted
    allowed = found && (!svc_any || win_lvl > svc_top);
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    unique case (ADDR_IN)
      OFS_ENABLE_A: rd_val = q.en_a;
      OFS_ENABLE_B: rd_val = q.en_b;
      OFS_PRIO_LOW_A: rd_val = q.pl_a;
      OFS_PRIO_HIGH_A: rd_val = q.ph_a;
      OFS_PRIO_LOW_B: rd_val = q.pl_b;
      OFS_PRIO_HIGH_B: rd_val = q.ph_b;
      OFS_SERIAL_STATUS: rd_val = q.ser_cfg;
      OFS_EVT_STATUS: rd_val = {4'h0, q.st};
      OFS_EVT_ENABLE: rd_val = {4'h0, q.ie};
      OFS_SERVICE: rd_val = {q.req, q.src, q.in_svc};
      default: rd_val = REG_RESET;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    ev = '0;
    d.rdata = REG_RESET;
    if (RD_IN) begin
      d.rdata = rd_val;
    end
    if (WR_IN) begin
      unique case (ADDR_IN)
        OFS_ENABLE_A: d.en_a = WDATA_IN;
        OFS_ENABLE_B: d.en_b = WDATA_IN;
        OFS_PRIO_LOW_A: d.pl_a = WDATA_IN;
        OFS_PRIO_HIGH_A: d.ph_a = WDATA_IN;
        OFS_PRIO_LOW_B: d.pl_b = WDATA_IN;
        OFS_PRIO_HIGH_B: d.ph_b = WDATA_IN;
        OFS_SERIAL_STATUS: d.ser_cfg = WDATA_IN & SERIAL_CFG_MASK;
        OFS_EVT_CLEAR: d.st = q.st & ~WDATA_IN[3:0];
        OFS_EVT_ENABLE: d.ie = WDATA_IN[3:0];
        default: d.en_a = q.en_a;
      endcase
    end
    // return first, so an entry in the same cycle is not wiped out
    if (RETI_IN) begin
      if (svc_any) begin
        d.in_svc[svc_top] = 1'b0;
        ev[EV_RETURN] = 1'b1;
      end else begin
        ev[EV_STRAY] = 1'b1;
      end
    end
    if (ACK_IN && q.req) begin
      d.req = 1'b0;
      d.in_svc[q.lvl] = 1'b1;
      ev[EV_ENTRY] = 1'b1;
      ev[EV_NEST] = svc_any;
    end else if (BOUNDARY_IN && !q.req && allowed) begin
      // request latched until the core takes it, even if the flag drops
      d.req = 1'b1;
      d.src = win_src;
      d.lvl = win_lvl;
      d.vec = SRC_VEC[win_src];
    end
    // set wins over a clear written in the same cycle
    d.st = d.st | ev;
    d.wake = |(raw & WAKE_MASK & {cand});
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign RDATA_OUT = q.rdata;
  assign REQ_OUT = q.req;
  assign VECTOR_OUT = q.vec;
  assign LEVEL_OUT = q.lvl;
  assign WAKE_OUT = q.wake;
  assign IRQ_OUT = |(q.st & q.ie);

  // ************************************************************
  // checks
  // ************************************************************
  logic [1:0] max_lvl;
  logic tie_bad;
  always_comb begin
    max_lvl = '0;
    tie_bad = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (cand[i] && src_level(3'(i), q) > max_lvl) begin
        max_lvl = src_level(3'(i), q);
      end
    end
    for (int j = 0; j < NSRC; j++) begin
      if (cand[j] && src_level(3'(j), q) == win_lvl
          && SRC_RANK[j] < SRC_RANK[win_src]) begin
        tie_bad = 1'b1;
      end
    end
  end

  logic [3:0] best_rank;
  logic [1:0] best_lvl;
  logic [7:0] at_win;

  // best_lvl is the level of the best-ranked candidate, whatever it is
  always_comb begin
    best_rank = '1;
    best_lvl = '0;
    at_win = '0;
    for (int k = 0; k < NSRC; k++) begin
      if (cand[k] && SRC_RANK[k] < best_rank) begin
        best_rank = SRC_RANK[k];
        best_lvl = src_level(3'(k), q);
      end
      at_win[k] = cand[k] && src_level(3'(k), q) == win_lvl;
    end
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  AST_LEVEL_MAX: assert property (
    $rose(q.req) |-> q.lvl == $past(max_lvl))
    else $error("taken level is not the highest pending");
  AST_SRC_ENABLED: assert property (
    $rose(q.req) |-> $past(pick_bit(win_src, q.en_a, q.en_b)))
    else $error("disabled source requested");
  AST_GLOBAL_GATE: assert property (
    !q.en_a[BIT_GLOBAL] && !q.req |=> !q.req)
    else $error("request raised with global enable clear");
  AST_PREEMPT_HIGHER: assert property (
    $rose(q.req) && $past(svc_any) |-> q.lvl > $past(svc_top))
    else $error("preemption by equal or lower level");
  AST_TOP_LOCK: assert property (
    q.in_svc[3] && !RETI_IN |=> !$rose(q.req))
    else $error("top level routine preempted");
  AST_AT_BOUNDARY: assert property (
    $rose(q.req) |-> $past(BOUNDARY_IN))
    else $error("request taken away from boundary");
  AST_TIE_RANK: assert property (
    $rose(q.req) |-> !$past(tie_bad))
    else $error("tie not resolved by rank");
  AST_VECTOR: assert property (
    q.req |-> VECTOR_OUT == SRC_VEC[q.src])
    else $error("vector does not match source");
  AST_WAKE_SRC: assert property (
    !(|(raw & WAKE_MASK)) |=> !WAKE_OUT)
    else $error("wake from a non-wake source");
  AST_TX_SPLIT: assert property (
    $rose(q.req) && q.src == SRC_STX |-> $past(q.ser_cfg[BIT_SPLIT]))
    else $error("transmit vector used without split");
  AST_SVC_ENTRY: assert property (
    ACK_IN && q.req |=> q.in_svc[$past(q.lvl)] && !q.req)
    else $error("in-service level not recorded");


  // ************************************************************
  // checks: ranking, serial routing, wake and events
  // ************************************************************
  // rank 1 wins every tie, whatever the rest of the table says
  AST_RANK_FIRST: assert property (
    $rose(q.req) && $past(cand[SRC_BO])
    |-> q.src == SRC_BO || q.lvl > $past(src_level(SRC_BO, q)))
    else $error("brownout lost a tie");
  AST_RANK_LAST: assert property (
    $rose(q.req) && q.src == SRC_SER |-> $past($countones(at_win)) == 1)
    else $error("combined serial won a tie");
  AST_RANK_NO_OVERRIDE: assert property (
    $rose(q.req) |-> q.lvl >= $past(best_lvl))
    else $error("polling rank overrode a higher level");
  AST_BOUNDARY_RAISE: assert property (
    BOUNDARY_IN && !q.req && allowed |=> q.req)
    else $error("eligible request not taken at boundary");
  AST_NO_CAND: assert property (
    !(|cand) && !q.req |=> !q.req)
    else $error("request raised with no enabled source");
  AST_TX_SHARED: assert property (
    FLAGS_IN.serial_tx_flag && !q.ser_cfg[BIT_SPLIT]
    |-> raw[SRC_SER] && !raw[SRC_STX])
    else $error("transmit not on shared vector");
  AST_TX_OWN: assert property (
    q.ser_cfg[BIT_SPLIT] |-> raw[SRC_STX] == FLAGS_IN.serial_tx_flag)
    else $error("transmit vector not following its flag");
  AST_RX_ONLY: assert property (
    q.ser_cfg[BIT_SPLIT] && !q.ser_cfg[BIT_EXTRA]
    && !FLAGS_IN.serial_rx_flag |-> !raw[SRC_SER])
    else $error("serial vector raised without receive");
  AST_EXTRA_ON: assert property (
    q.ser_cfg[BIT_EXTRA] && (FLAGS_IN.framing_error_flag
    || FLAGS_IN.break_flag || FLAGS_IN.overrun_flag) |-> raw[SRC_SER])
    else $error("extra serial flag ignored");
  AST_EXTRA_OFF: assert property (
    !q.ser_cfg[BIT_EXTRA] && !FLAGS_IN.serial_rx_flag
    && !FLAGS_IN.serial_tx_flag |-> !raw[SRC_SER])
    else $error("serial request without serial flag");
  AST_KEYPAD_WAKE: assert property (
    cand[SRC_KB] |=> WAKE_OUT)
    else $error("enabled keypad did not wake");
  AST_WAKE_LISTED: assert property (
    $rose(WAKE_OUT) |-> $past(|(cand & WAKE_MASK)))
    else $error("wake without an enabled wake source");
  AST_WAKE_GLOBAL: assert property (
    !q.en_a[BIT_GLOBAL] |=> !WAKE_OUT)
    else $error("wake with global enable clear");
  AST_SVC_RETURN: assert property (
    RETI_IN && svc_any && !(ACK_IN && q.req)
    |=> !q.in_svc[$past(svc_top)])
    else $error("return left its level in service");
  // a latched request must not move under the core while it fetches
  AST_REQ_STANDS: assert property (
    q.req && !ACK_IN |=> q.req && $stable(q.vec) && $stable(q.lvl))
    else $error("request withdrawn or changed before ack");
  // events must survive a clear written in the same cycle
  AST_EVT_ENTRY: assert property (
    ACK_IN && q.req |=> q.st[EV_ENTRY])
    else $error("entry event not recorded");
  AST_EVT_NEST: assert property (
    ACK_IN && q.req && svc_any |=> q.st[EV_NEST])
    else $error("nested entry event not recorded");
  AST_EVT_STRAY: assert property (
    RETI_IN && !svc_any |=> q.st[EV_STRAY])
    else $error("stray return not recorded");
  AST_RDATA_IDLE: assert property (
    !RD_IN |=> RDATA_OUT == REG_RESET)
    else $error("read data outside its cycle");
  AST_CFG_BITS: assert property (
    (q.ser_cfg & ~SERIAL_CFG_MASK) == REG_RESET)
    else $error("reserved serial status bit set");

  COV_SPLIT_TX: cover property ($rose(q.req) && q.src == SRC_STX);
  COV_NEST: cover property ($rose(q.req) && svc_any);
  COV_TIE: cover property ($rose(q.req) ##0 $past($countones(cand)) > 1);
  COV_RETURN: cover property (RETI_IN && svc_any ##1 !svc_any);
  COV_WAKE: cover property ($rose(WAKE_OUT));

endmodule

// ### test/fic_core_model.sv
// core stand-in: marks boundaries, takes vectors, issues returns
// assumes the controller's core port on the same clock
`timescale 1ns/1ps
module fic_core_model
  import fic_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // controller side
  input wire logic req_in,
  input wire logic [15:0] vec_in,
  input wire logic [1:0] lvl_in,
  output logic boundary_out,
  output logic ack_out,
  output logic reti_out,
  // bench side
  input wire logic slow_in,
  input wire logic reti_cmd_in,
  output int took_out,
  output logic [15:0] vec_out,
  output logic [1:0] lvl_out
);
  logic [1:0] wait_reg;
  // ********
  // core behaviour
  // ********
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      boundary_out <= 1'b0;
      ack_out <= 1'b0;
      reti_out <= 1'b0;
      wait_reg <= 2'h0;
      took_out <= 0;
      vec_out <= 16'h0000;
      lvl_out <= 2'h0;
    end else begin
      // every cycle is a boundary while nothing is offered
      boundary_out <= !req_in;
      reti_out <= reti_cmd_in;
      ack_out <= 1'b0;
      wait_reg <= 2'h0;
      if (req_in && !ack_out) begin
        wait_reg <= wait_reg + 2'h1;
        // a slow core lets the request stand four cycles
        ack_out <= !slow_in || wait_reg == 2'h3;
      end
      if (req_in && ack_out) begin
        took_out <= took_out + 1;
        vec_out <= vec_in;
        lvl_out <= lvl_in;
      end
    end
  end
endmodule

// ### test/tb_fic_ctrl.sv
// bench for the interrupt controller: registers, arbitration, wake
// assumes fic_core_model stands in for the processor core
`timescale 1ns/1ps
module tb_fic_ctrl
  import fic_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [11:0] fl = 12'h000;
  logic slow = 1'b0;
  logic reti_cmd = 1'b0;
  logic [7:0] rdata;
  logic bnd, ack, ret, req, wake, irq;
  logic [15:0] vec, cvec;
  logic [1:0] lvl, clvl;
  int took, seen, err_count, samples_checked;
  logic [15:0] rk_vec [0:7] = '{16'h002b, 16'h0053, 16'h000b, 16'h003b,
                                16'h001b, 16'h0043, 16'h006b, 16'h0023};
  int rk_bit [0:7] = '{9, 8, 11, 6, 10, 5, 4, 3};

  fic_ctrl u_fic_ctrl (
    .CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr_en), .RD_IN(rd_en), .RDATA_OUT(rdata),
    .FLAGS_IN(fic_flags_type'(fl)), .BOUNDARY_IN(bnd), .ACK_IN(ack),
    .RETI_IN(ret), .REQ_OUT(req), .VECTOR_OUT(vec), .LEVEL_OUT(lvl),
    .WAKE_OUT(wake), .IRQ_OUT(irq));
  fic_core_model u_fic_core_model (
    .clk_in(clk), .rstn_in(rstn), .req_in(req), .vec_in(vec),
    .lvl_in(lvl), .boundary_out(bnd), .ack_out(ack), .reti_out(ret),
    .slow_in(slow), .reti_cmd_in(reti_cmd), .took_out(took),
    .vec_out(cvec), .lvl_out(clvl));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ********
  // shared tasks
  // ********
  task automatic chk_val(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic reg_wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic reg_chk(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk_val("rdata", 16'(e), 16'(rdata));
  endtask
  task automatic set_fl(logic [11:0] v);
    @(posedge clk);
    fl <= v;
  endtask
  // new flags plus one return from the core
  task automatic fin(logic [11:0] v);
    @(posedge clk);
    fl <= v;
    reti_cmd <= 1'b1;
    @(posedge clk);
    reti_cmd <= 1'b0;
  endtask
  task automatic take(logic [15:0] v, logic [1:0] l);
    for (int i = 0; i < 40 && took == seen; i++) @(posedge clk);
    #1;
    chk_bit("taken", 1'b1, took != seen);
    seen = took;
    chk_val("vector", v, cvec);
    chk_val("level", 16'(l), 16'(clvl));
  endtask
  task automatic no_take();
    repeat (20) @(posedge clk);
    #1 chk_val("quiet", 16'(seen), 16'(took));
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_regs();
    for (int a = 0; a < 16; a++) reg_chk(4'(a), 8'h00);
    reg_wr(OFS_SERIAL_STATUS, 8'hff);
    reg_chk(OFS_SERIAL_STATUS, 8'h21);
    reg_wr(4'hc, 8'hff);
    reg_chk(4'hc, 8'h00);
    // a return with nothing in service is a stray event
    fin(12'h000);
    reg_chk(OFS_EVT_STATUS, 8'h08);
    reg_wr(OFS_EVT_CLEAR, 8'h08);
    reg_wr(OFS_SERIAL_STATUS, 8'h00);
  endtask
  task automatic t_gate();
    reg_wr(OFS_EVT_ENABLE, 8'h01);
    set_fl(12'h800);
    reg_wr(OFS_ENABLE_A, 8'h02);
    no_take();
    reg_wr(OFS_ENABLE_A, 8'h80);
    no_take();
    reg_wr(OFS_ENABLE_A, 8'h82);
    take(16'h000b, 2'h0);
    chk_bit("irq", 1'b1, irq);
    reg_chk(OFS_SERVICE, 8'h01);
    fin(12'h000);
    reg_chk(OFS_EVT_STATUS, 8'h05);
    reg_wr(OFS_EVT_CLEAR, 8'h05);
    #1 chk_bit("irq", 1'b0, irq);
    reg_wr(OFS_EVT_ENABLE, 8'h00);
  endtask
  task automatic t_rank();
    reg_wr(OFS_ENABLE_A, 8'hfa);
    reg_wr(OFS_ENABLE_B, 8'h46);
    reg_wr(OFS_SERIAL_STATUS, 8'h20);
    set_fl(12'hf78);
    for (int i = 0; i < 8; i++) begin
      take(rk_vec[i], 2'h0);
      fin(fl & ~(12'h001 << rk_bit[i]));
      repeat (2) @(posedge clk);
      #1 chk_bit("wake", |(fl & 12'h3e0), wake);
    end
    chk_bit("irq", 1'b0, irq);
  endtask
  task automatic t_prio();
    slow <= 1'b1;
    reg_wr(OFS_PRIO_LOW_A, 8'h4a);
    reg_wr(OFS_PRIO_HIGH_A, 8'h40);
    reg_wr(OFS_PRIO_LOW_B, 8'h04);
    reg_wr(OFS_PRIO_HIGH_B, 8'h06);
    set_fl(12'h600);
    take(16'h001b, 2'h1);
    set_fl(12'ha00);
    no_take();
    set_fl(12'ha40);
    take(16'h003b, 2'h2);
    set_fl(12'ha20);
    take(16'h0043, 2'h3);
    set_fl(12'hb00);
    no_take();
    fin(12'hb00);
    take(16'h0053, 2'h3);
    for (int i = 0; i < 3; i++) fin(12'h000);
    no_take();
  endtask
  task automatic t_ser();
    for (int a = 2; a < 6; a++) reg_wr(4'(a), 8'h00);
    reg_wr(OFS_SERIAL_STATUS, 8'h00);
    set_fl(12'h010);
    take(16'h0023, 2'h0);
    fin(12'h000);
    reg_wr(OFS_SERIAL_STATUS, 8'h01);
    for (int b = 0; b < 3; b++) begin
      set_fl(12'h001 << b);
      take(16'h0023, 2'h0);
      fin(12'h000);
    end
    reg_wr(OFS_SERIAL_STATUS, 8'h00);
    set_fl(12'h004);
    no_take();
  endtask

  task automatic results();
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // the whole run is some four hundred cycles; the time limit is forty thousand
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_gate();
    t_rank();
    t_prio();
    t_ser();
    results();
  end
endmodule
